// File: hbsd_ctrl.sv
// Purpose: host-side controller driving a half-bridge gate driver's pins
// Assumes: all inputs synchronous to core_clk; halt pin is open drain
// Notes:   command is forced low until power-up and bootstrap are done
// Contract
// - host holds halt low at least 450 ns.
// - host pulses clear at least 2.4 us to release the latch.
// - host must not drive halt high after latch; open drain.
// - host waits 50 us power-on settling before operating.
// - host issues a clear pulse as part of power-up.
// - host holds command low until bootstrap has charged.
`timescale 1ns/1ps
module hbsd_ctrl
	import hbsd_pkg::*;
#(
	parameter int POR_CYC  = hbsd_pkg::POR_SETTLE_CYC,
	parameter int BOOT_CYC = hbsd_pkg::BOOT_CHARGE_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic        pwm_in,
	input  wire logic        halt_req,
	input  wire logic        rearm_req,
	input  wire logic        halt_request_n_in,
	output logic             halt_request_n_out,
	output logic             halt_request_n_oe,
	output logic             halt_clear,
	output logic             drive_cmd,
	output logic             ready,
	output logic             halted
);
	import hbsd_pkg::*;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	if (POR_CYC < 1 || POR_CYC >= (1 << CNT_W)) begin : g_bad_por
		$error("POR_CYC out of range");
	end
	if (BOOT_CYC < 1 || BOOT_CYC >= (1 << CNT_W)) begin : g_bad_boot
		$error("BOOT_CYC out of range");
	end

	typedef struct packed {
		hbsd_state_t st;
		logic        oe;
		logic        clr;
		logic        cmd;
		logic        rdy;
		logic        hlt;
		logic        ld;
		logic [CNT_W-1:0] ldv;
	} hbsd_ctl_t;
	hbsd_ctl_t s_reg;
	hbsd_ctl_t s_next;
	logic      t_done;

	hbsd_timer #(.W(CNT_W)) u_tmr (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.load     (s_reg.ld),
		.load_val (s_reg.ldv),
		.done     (t_done)
	);

	always_comb begin
		s_next     = s_reg;
		s_next.ld  = 1'b0;
		s_next.ldv = '0;
		unique case (s_reg.st)
			HBSD_POR: begin
				// wait settling before any pin activity
				if (t_done && !s_reg.ld) begin
					s_next.st  = HBSD_CLEAR;
					s_next.clr = 1'b1;
					s_next.ld  = 1'b1;
					s_next.ldv = CNT_W'(CLEAR_MIN_CYC);
				end
			end
			HBSD_CLEAR: begin
				if (t_done && !s_reg.ld) begin
					s_next.clr = 1'b0;
					s_next.st  = HBSD_BOOT;
					s_next.ld  = 1'b1;
					s_next.ldv = CNT_W'(BOOT_CYC);
				end
			end
			HBSD_BOOT: begin
				// command kept low while bootstrap charges
				if (t_done && !s_reg.ld) begin
					s_next.st  = HBSD_RUN;
					s_next.rdy = 1'b1;
				end
			end
			HBSD_RUN: begin
				s_next.cmd = pwm_in;
				if (halt_req) begin
					s_next.st  = HBSD_HALT;
					s_next.oe  = 1'b1;
					s_next.cmd = 1'b0;
					s_next.rdy = 1'b0;
					s_next.ld  = 1'b1;
					s_next.ldv = CNT_W'(HALT_MIN_CYC);
				end
			end
			HBSD_HALT: begin
				// hold halt low for the minimum pulse
				if (t_done && !s_reg.ld) begin
					s_next.oe  = 1'b0; // release, never drive high
					s_next.st  = HBSD_LATCH;
					s_next.hlt = 1'b1;
				end
			end
			HBSD_LATCH: begin
				if (rearm_req) begin
					s_next.st  = HBSD_REARM;
					s_next.clr = 1'b1;
					s_next.ld  = 1'b1;
					s_next.ldv = CNT_W'(CLEAR_MIN_CYC);
				end
			end
			HBSD_REARM: begin
				if (t_done && !s_reg.ld) begin
					s_next.clr = 1'b0;
					s_next.hlt = 1'b0;
					s_next.st  = HBSD_BOOT;
					s_next.ld  = 1'b1;
					s_next.ldv = CNT_W'(BOOT_CYC);
				end
			end
			default: begin
				s_next.st = HBSD_POR;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_reg     <= '0;
			s_reg.st  <= HBSD_POR;
			s_reg.ld  <= 1'b1;
			s_reg.ldv <= CNT_W'(POR_CYC);
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	assign halt_request_n_out = 1'b0;
	assign halt_request_n_oe  = s_reg.oe;
	assign halt_clear         = s_reg.clr;
	assign drive_cmd          = s_reg.cmd;
	assign ready              = s_reg.rdy;
	assign halted             = s_reg.hlt;

	// helper counters for pulse widths
	logic [CNT_W-1:0] oe_len;
	logic [CNT_W-1:0] clr_len;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			oe_len  <= '0;
			clr_len <= '0;
		end else if (clk_en) begin
			oe_len  <= s_reg.oe ? oe_len + 1'b1 : '0;
			clr_len <= s_reg.clr ? clr_len + 1'b1 : '0;
		end
	end

	// pin drive sequence checks
	a_halt_width: assert property (
		$fell(s_reg.oe) |-> oe_len >= CNT_W'(HALT_MIN_CYC))
		else $error("halt pulse too short");
	a_clear_width: assert property (
		$fell(s_reg.clr) |-> clr_len >= CNT_W'(CLEAR_MIN_CYC))
		else $error("clear pulse too short");
	a_cmd_low_halt: assert property (
		s_reg.oe |-> !s_reg.cmd)
		else $error("command high while halting");
	a_no_drive_hi: assert property (
		halt_request_n_oe |-> !halt_request_n_out && !s_reg.hlt && !s_reg.clr)
		else $error("halt pin driven while latched");
	a_cmd_not_ready: assert property (
		!s_reg.rdy |=> !s_reg.cmd)
		else $error("command before ready");
	a_por_clear: assert property (
		$rose(s_reg.clr) && !$past(s_reg.hlt) |-> $past(s_reg.st) == HBSD_POR)
		else $error("power-up clear out of order");
	a_settle_wait: assert property (
		s_reg.st == HBSD_POR |-> !s_reg.clr && !s_reg.oe)
		else $error("pins active during settling");
	a_rearm_path: assert property (
		s_reg.st == HBSD_LATCH |-> !s_reg.oe && !s_reg.cmd)
		else $error("driving pins while latched");
	a_halt_from_run: assert property (
		$rose(s_reg.oe) |-> $past(s_reg.st) == HBSD_RUN)
		else $error("halt pulse outside normal run");
	a_ready_clean: assert property (
		s_reg.rdy |-> !s_reg.clr && !s_reg.oe && !s_reg.hlt)
		else $error("ready while pins active");
	a_rearm_clear: assert property (
		$fell(s_reg.hlt) |-> $past(s_reg.clr))
		else $error("latch left without clear pulse");
	a_release_latch: assert property (
		$fell(s_reg.oe) |-> s_reg.hlt)
		else $error("halt released without latch state");

	c_ready: cover property ($rose(s_reg.rdy));
	c_halt:  cover property ($rose(s_reg.hlt));
	c_rearm: cover property ($fell(s_reg.hlt));
	c_power: cover property ($rose(s_reg.clr) && s_reg.st == HBSD_CLEAR);
	c_pulse: cover property ($rose(s_reg.oe));
endmodule : hbsd_ctrl

// File: hbsd_dev_model.sv
// Purpose: behavioural gate driver seen by the controller
// Assumes: halt pin has a pull-up; times in ns
// Notes:   gates are observed by the bench
`timescale 1ns/1ps
module hbsd_dev_model #(
	parameter int GAP = 120
) (
	input  wire logic cmd,
	input  wire logic halt_pin,
	input  wire logic clr,
	input  wire logic uv_fault,
	output logic      latch_oe,
	output logic      upper_gate_out,
	output logic      lower_gate_out
);
	logic cmd_dly;
	logic lo_en;
	logic uv_block;
	initial begin
		latch_oe = 1'b0;
		lo_en = 1'b0;
		uv_block = 1'b0;
	end
	assign #(GAP) cmd_dly = cmd;
	always @(negedge halt_pin) begin
		#260;
		if (!halt_pin && !clr) latch_oe = 1'b1;
	end
	always @(posedge clr) begin
		#1000;
		if (clr) begin
			latch_oe = 1'b0;
			lo_en = 1'b1;
		end
	end
	// undervoltage blocks gates until the next command rising edge seen with uv_fault low
	always @(posedge uv_fault) uv_block = 1'b1;
	always @(posedge cmd) begin
		if (!uv_fault) uv_block = 1'b0;
	end
	assign upper_gate_out = halt_pin & !uv_block & cmd & cmd_dly;
	assign lower_gate_out = halt_pin & !uv_block & lo_en & !cmd & !cmd_dly;
endmodule : hbsd_dev_model

// File: hbsd_pkg.sv
// Purpose: constants for the half-bridge driver controller
// Assumes: core_clk at 200 MHz
// Notes:   times in ns, cycle counts derived from the clock period
package hbsd_pkg;
	localparam int CLK_PERIOD_NS     = 5;
	localparam int HALT_MIN_NS       = 450;
	localparam int CLEAR_MIN_NS      = 2400;
	localparam int POR_SETTLE_NS     = 50000;
	localparam int BOOT_CHARGE_NS    = 100000;
	localparam int GAP_NS            = 120;
	localparam int HALT_MIN_CYC      = (HALT_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CLEAR_MIN_CYC     = (CLEAR_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int POR_SETTLE_CYC    = (POR_SETTLE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int BOOT_CHARGE_CYC   = (BOOT_CHARGE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int GAP_CYC           = (GAP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CNT_W             = 16;

	typedef enum logic [2:0] {
		HBSD_POR    = 3'b000,
		HBSD_CLEAR  = 3'b001,
		HBSD_BOOT   = 3'b010,
		HBSD_RUN    = 3'b011,
		HBSD_HALT   = 3'b100,
		HBSD_LATCH  = 3'b101,
		HBSD_REARM  = 3'b110
	} hbsd_state_t;
endpackage : hbsd_pkg

// File: hbsd_timer.sv
// Purpose: loadable down counter with done flag
// Assumes: load wins over counting
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
module hbsd_timer #(
	parameter int W = 16
) (
	input  wire logic          core_clk,
	input  wire logic          sys_rst,
	input  wire logic          clk_en,
	input  wire logic          load,
	input  wire logic [W-1:0]  load_val,
	output logic               done
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} hbsd_tmr_t;
	hbsd_tmr_t s_reg;
	hbsd_tmr_t s_next;

	if (W < 2) begin : g_bad_w
		$error("hbsd_timer width too small");
	end

	always_comb begin
		s_next = s_reg;
		if (load) begin
			s_next.cnt = load_val;
		end else if (s_reg.cnt != '0) begin
			s_next.cnt = s_reg.cnt - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	assign done = (s_reg.cnt == '0);
endmodule : hbsd_timer

// File: tb_hbsd_ctrl.sv
// Purpose: self-checking bench for the half-bridge controller
// Assumes: small power-up counts
// Notes:   halt pin resolved from both open-drain pulls
`timescale 1ns/1ps
module tb_hbsd_ctrl;
	import hbsd_pkg::*;
	localparam int PC = 20;
	localparam int BC = 20;
	logic core_clk, sys_rst, clk_en, pwm_in, halt_req, rearm_req;
	logic uv_fault;
	logic oe, hout, clr, cmd, ready, halted, latch_oe, hi_g, lo_g;
	wire  halt_pin = !((oe & !hout) | latch_oe);
	int   n_errors = 0;
	int   tests_run = 0;
	int   n;
	hbsd_ctrl #(.POR_CYC(PC), .BOOT_CYC(BC)) hbsd_ctrl_i (
		.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.pwm_in(pwm_in), .halt_req(halt_req), .rearm_req(rearm_req),
		.halt_request_n_in(halt_pin), .halt_request_n_out(hout),
		.halt_request_n_oe(oe), .halt_clear(clr), .drive_cmd(cmd),
		.ready(ready), .halted(halted));
	hbsd_dev_model #(.GAP(GAP_NS)) hbsd_dev_model_i (.cmd(cmd),
		.halt_pin(halt_pin), .clr(clr), .uv_fault(uv_fault),
		.latch_oe(latch_oe), .upper_gate_out(hi_g),
		.lower_gate_out(lo_g));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic check(input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %b want %b", $time, seen, exp);
		end
	endtask : check
	function automatic logic sig(input int k);
		return k == 0 ? clr : (k == 1 ? oe : ready);
	endfunction : sig
	// counts cycles while the chosen output keeps the given level
	task automatic span(input int k, input logic lvl, output int c);
		c = 0;
		while (sig(k) === lvl && c < 20000) begin
			@(posedge core_clk);
			#1;
			c++;
		end
	endtask : span
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	task automatic t_powerup();
		clk_en = 1'b0;
		repeat (10) @(posedge core_clk);
		#1;
		clk_en = 1'b1;
		span(0, 1'b0, n);
		check(n >= PC, 1'b1);
		check(cmd, 1'b0);
		span(0, 1'b1, n);
		check(n >= CLEAR_MIN_CYC, 1'b1);
		span(2, 1'b0, n);
		check(n >= BC, 1'b1);
		repeat (30) @(posedge core_clk);
		#1;
		check(hi_g, 1'b1);
		pwm_in = 1'b0;
		repeat (30) @(posedge core_clk);
		#1;
		check(lo_g, 1'b1);
		check(hi_g, 1'b0);
		pwm_in = 1'b1;
	endtask : t_powerup
	task automatic t_uvlo();
		repeat (30) @(posedge core_clk);
		#1;
		check(hi_g, 1'b1);
		uv_fault = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		check(hi_g, 1'b0);
		uv_fault = 1'b0;
		repeat (30) @(posedge core_clk);
		#1;
		check(hi_g, 1'b0);
		check(halt_pin, 1'b1);
		check(halted, 1'b0);
		pwm_in = 1'b0;
		repeat (30) @(posedge core_clk);
		#1;
		pwm_in = 1'b1;
		repeat (30) @(posedge core_clk);
		#1;
		check(hi_g, 1'b1);
	endtask : t_uvlo
	task automatic t_halt();
		rearm_req = 1'b1;
		repeat (5) @(posedge core_clk);
		#1;
		check(clr, 1'b0);
		rearm_req = 1'b0;
		halt_req = 1'b1;
		span(1, 1'b0, n);
		check(n <= 2, 1'b1);
		halt_req = 1'b0;
		check(hout, 1'b0);
		span(1, 1'b1, n);
		check(n >= HALT_MIN_CYC, 1'b1);
		check(halt_pin, 1'b0);
		check(hi_g, 1'b0);
		check(halted, 1'b1);
		check(ready, 1'b0);
	endtask : t_halt
	task automatic t_rearm();
		rearm_req = 1'b1;
		span(0, 1'b0, n);
		check(n <= 2, 1'b1);
		rearm_req = 1'b0;
		span(0, 1'b1, n);
		check(n >= CLEAR_MIN_CYC, 1'b1);
		check(halt_pin, 1'b1);
		span(2, 1'b0, n);
		check(n >= BC, 1'b1);
		repeat (30) @(posedge core_clk);
		#1;
		check(hi_g, 1'b1);
	endtask : t_rearm
	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		pwm_in = 1'b1;
		halt_req = 1'b0;
		rearm_req = 1'b0;
		uv_fault = 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		check(clr | oe | cmd | ready | halted, 1'b0);
		sys_rst = 1'b0;
		t_powerup();
		t_uvlo();
		t_halt();
		t_rearm();
		conclude();
	end
	initial begin
		#200000;
		n_errors++;
		conclude();
	end
endmodule : tb_hbsd_ctrl
